// ### epedet_top.sv
/*
 Excessive position error detector. Compares commanded and feedback
 positions each control cycle, derives a pulse threshold from the
 trigger level and exposes the remaining margin and an alarm.
 The threshold is floored to whole pulses, and products wider than
 the margin width wrap, so huge levels on fine linear scales are out.
 While a refresh runs, the old alarm threshold stays in force for
 one divider pass and the old warning threshold for two.
 Assumes settings come from the same clock domain, held steady while
 a threshold recomputation runs, so no synchronisers are fitted.
 Assumes the position error stays below 2^31 pulses.
*/
// Summary of operation
// - A rotary motor reads the trigger level in revolutions.
// - A linear motor reads the trigger level in millimetres.
// - Rotary levels of 200 rev or above are clamped to 200 rev.
// - A zero level selects 3 rev or 100 mm, and zero is its reset value.
// - Unit codes 0..3 scale the level by 1, 0.1, 0.01 and 0.001.
// - The unit selection scales both the alarm and warning levels.
// - Scaling applies only in position and positioning modes.
// - The margin in pulses is greatest at zero error, shrinking with it.
// - The alarm is raised when the margin reaches zero pulses.
// - Fully closed loop uses the load-side resolution per revolution.
// - Linear resolution per rev is numerator over denominator times 1000.
`timescale 1ns/1ps
module epedet_top #(
  parameter int POS_W = epedet_pkg::POS_W,
  parameter int RES_W = epedet_pkg::RES_W
) (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  // Control cycle strobe and positions
  input wire logic I_CYCLE,
  input wire logic signed [POS_W-1:0] I_CMD_POS,
  input wire logic signed [POS_W-1:0] I_FB_POS,
  // Motor and loop kind
  input wire logic I_LINEAR_MOTOR,
  input wire logic I_FULL_CLOSED,
  input wire logic I_LINEAR_ENCODER,
  input wire logic [1:0] I_CONTROL_MODE,
  // Trigger levels and unit
  input wire logic [15:0] I_TRIGGER_LEVEL_PARAM,
  input wire logic [15:0] I_WARNING_LEVEL_PARAM,
  input wire logic [1:0] I_UNIT_SELECT_PARAM,
  // Encoder resolutions
  input wire logic [RES_W-1:0] I_MOTOR_RES,
  input wire logic [RES_W-1:0] I_LOAD_RES,
  input wire logic [15:0] I_LINEAR_RES_NUMERATOR,
  input wire logic [15:0] I_LINEAR_RES_DENOMINATOR,
  // Thresholds and margin
  output logic [47:0] O_MARGIN,
  output logic [47:0] O_ALARM_PULSES,
  output logic [47:0] O_WARNING_PULSES,
  // Validity and flags
  output logic O_THRESH_VALID,
  output logic O_EXCESSIVE_ERROR_ALARM,
  output logic O_EXCESSIVE_ERROR_WARNING
);
  // Margin width, room for 200 rev at fine resolutions
  localparam int MW = epedet_pkg::MRG_W;

  typedef struct packed {
    logic [MW-1:0] margin;
    logic [MW-1:0] alarm_pls;
    logic [MW-1:0] warn_pls;
    logic valid;
    logic alarm;
    logic warn;
    // Low: alarm pass, high: warning pass
    logic phase;
    // Settings signature of the last alarm pass
    logic [MW-1:0] cfg_sig;
  } epedet_st_t;

  epedet_st_t st_r;
  epedet_st_t st_nxt;

  // Effective level in whole units times 1000 (milli-units)
  function automatic logic [MW-1:0] epedet_milli(
    input logic [15:0] lvl, input logic lin, input logic [1:0] unit,
    input logic scaled);
    logic [MW-1:0] base;
    logic [MW-1:0] milli;
    base = MW'(lvl);
    // Zero level: default in whole units, unit code unused
    if (lvl == 16'h0000) begin
      base = lin ? MW'(epedet_pkg::LIN_DEFAULT_MM)
                 : MW'(epedet_pkg::ROT_DEFAULT_REV);
    end
    // Whole units unless a finer unit applies
    milli = base * MW'(epedet_pkg::LIN_RES_SCALE);
    if (scaled && lvl != 16'h0000) begin
      case (unit)
        epedet_pkg::UNIT_TENTH: milli = base * MW'(100);
        epedet_pkg::UNIT_HUNDREDTH: milli = base * MW'(10);
        epedet_pkg::UNIT_THOUSANDTH: milli = base;
        default: milli = base * MW'(epedet_pkg::LIN_RES_SCALE);
      endcase
    end
    // Clamp after scaling so no unit can pass 200 rev
    if (!lin && milli >= MW'(epedet_pkg::ROT_CLAMP_REV) *
        MW'(epedet_pkg::LIN_RES_SCALE)) begin
      milli = MW'(epedet_pkg::ROT_CLAMP_REV) *
              MW'(epedet_pkg::LIN_RES_SCALE);
    end
    return milli;
  endfunction : epedet_milli

  // Resolution and scaling selection
  logic scaled;
  logic [MW-1:0] res;
  logic [MW-1:0] res_den;
  logic [MW-1:0] cfg_now;
  logic [MW-1:0] lvl_milli;
  // Divider handshake
  logic div_start;
  logic div_busy;
  logic div_done;
  logic [MW-1:0] div_quot;
  // Absolute error
  logic [MW-1:0] diff;

  // Resolution choice, scaling gate and settings signature
  always_comb begin
    scaled = (I_CONTROL_MODE == epedet_pkg::MODE_POSITION) ||
             (I_CONTROL_MODE == epedet_pkg::MODE_POSITIONING);
    res = MW'(I_MOTOR_RES);
    res_den = MW'(1);
    // Load side takes over in fully closed loop
    if (I_FULL_CLOSED) begin
      res = MW'(I_LOAD_RES);
    end
    // A linear encoder overrides both rotary resolutions
    if (I_LINEAR_ENCODER) begin
      res = MW'(I_LINEAR_RES_NUMERATOR) *
            MW'(epedet_pkg::LIN_RES_SCALE);
      res_den = MW'(I_LINEAR_RES_DENOMINATOR);
      // A zero denominator counts as one
      if (I_LINEAR_RES_DENOMINATOR == 16'h0000) begin
        res_den = MW'(1);
      end
    end
    // Same unit drives both levels
    lvl_milli = epedet_milli(st_r.phase ? I_WARNING_LEVEL_PARAM
                             : I_TRIGGER_LEVEL_PARAM, I_LINEAR_MOTOR,
                             I_UNIT_SELECT_PARAM, scaled);
    // Any settings change reruns both passes
    cfg_now = {I_TRIGGER_LEVEL_PARAM, I_WARNING_LEVEL_PARAM,
               I_UNIT_SELECT_PARAM, I_CONTROL_MODE, I_LINEAR_MOTOR,
               I_FULL_CLOSED, I_LINEAR_ENCODER, 9'h000} ^
              MW'(I_MOTOR_RES) ^ (MW'(I_LOAD_RES) << 8) ^
              MW'({I_LINEAR_RES_NUMERATOR, I_LINEAR_RES_DENOMINATOR});
  end

  // Pulse threshold = milli-level * res / (1000 * den)
  // Phase high chains the warning pass onto the alarm pass
  assign div_start = !div_busy && !div_done &&
                     (!st_r.valid || cfg_now != st_r.cfg_sig || st_r.phase);

  epedet_div #(.W(MW)) u_div (
    .i_clk(I_SYS_CLK),
    .i_rst_n(I_RST_N),
    .i_start(div_start),
    .i_num(MW'(lvl_milli * res)),
    .i_den(MW'(res_den * MW'(epedet_pkg::LIN_RES_SCALE))),
    .o_busy(div_busy),
    .o_done(div_done),
    .o_quot(div_quot)
  );

  // Absolute error in pulses
  always_comb begin
    // Signed compare first, so the subtraction never goes negative
    diff = (I_CMD_POS >= I_FB_POS)
           ? MW'(unsigned'(I_CMD_POS - I_FB_POS))
           : MW'(unsigned'(I_FB_POS - I_CMD_POS));
  end

  // Threshold capture and per-cycle margin update
  always_comb begin
    st_nxt = st_r;
    // Signature taken as the alarm pass starts
    if (div_start && !st_r.phase) begin
      st_nxt.cfg_sig = cfg_now;
    end
    // First pass yields the alarm level, second the warning
    if (div_done) begin
      if (!st_r.phase) begin
        st_nxt.alarm_pls = div_quot;
        st_nxt.phase = 1'b1;
      end else begin
        st_nxt.warn_pls = div_quot;
        st_nxt.phase = 1'b0;
        st_nxt.valid = 1'b1;
      end
    end
    // Taken cycle: margin, sticky alarm, warning
    if (I_CYCLE && st_r.valid) begin
      st_nxt.margin = (diff >= st_r.alarm_pls) ? '0
                      : st_r.alarm_pls - diff;
      st_nxt.alarm = st_r.alarm | (diff >= st_r.alarm_pls);
      st_nxt.warn = diff >= st_r.warn_pls;
    end
  end

  // State register
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign O_MARGIN = st_r.margin;
  assign O_ALARM_PULSES = st_r.alarm_pls;
  assign O_WARNING_PULSES = st_r.warn_pls;
  assign O_THRESH_VALID = st_r.valid;
  assign O_EXCESSIVE_ERROR_ALARM = st_r.alarm;
  assign O_EXCESSIVE_ERROR_WARNING = st_r.warn;
endmodule : epedet_top

// ### epedet_pkg.sv
/*
 Package for the excessive position error detector: reset values,
 default thresholds, clamp limits and unit-selection codes.
 Assumes nothing of its surroundings.
*/
package epedet_pkg;
  // Widths
  localparam int POS_W = 32;
  localparam int LVL_W = 16;
  localparam int RES_W = 24;
  localparam int MRG_W = 48;
  // Reset values of the settings
  localparam logic [15:0] LEVEL_RST = 16'h0000;
  localparam logic [1:0] UNIT_RST = 2'h0;
  // Defaults selected by a zero level, in whole units
  localparam logic [15:0] ROT_DEFAULT_REV = 16'h0003;
  localparam logic [15:0] LIN_DEFAULT_MM = 16'h0064;
  // Rotary clamp, in whole revolutions
  localparam logic [15:0] ROT_CLAMP_REV = 16'h00C8;
  // Linear encoder scale factor
  localparam logic [15:0] LIN_RES_SCALE = 16'h03E8;
  // Unit selection codes
  localparam logic [1:0] UNIT_ONE = 2'h0;
  localparam logic [1:0] UNIT_TENTH = 2'h1;
  localparam logic [1:0] UNIT_HUNDREDTH = 2'h2;
  localparam logic [1:0] UNIT_THOUSANDTH = 2'h3;
  // Control mode codes
  localparam logic [1:0] MODE_POSITION = 2'h0;
  localparam logic [1:0] MODE_POSITIONING = 2'h1;
  localparam logic [1:0] MODE_VELOCITY = 2'h2;
  localparam logic [1:0] MODE_TORQUE = 2'h3;
endpackage : epedet_pkg

// ### epedet_div.sv
/*
 Sequential unsigned divider: one quotient bit per clock.
 Assumes a start pulse while idle; result valid with done pulse.
*/
`timescale 1ns/1ps
module epedet_div #(
  parameter int W = 48
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Request
  input wire logic i_start,
  input wire logic [W-1:0] i_num,
  input wire logic [W-1:0] i_den,
  // Answer
  output logic o_busy,
  output logic o_done,
  output logic [W-1:0] o_quot
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [7:0] cnt;
    logic [W-1:0] num;
    logic [W-1:0] den;
    logic [W-1:0] rem;
    logic [W-1:0] quot;
  } epedet_div_st_t;

  epedet_div_st_t st_r;
  epedet_div_st_t st_nxt;
  logic [W:0] trial;

  // Restoring division step
  always_comb begin
    st_nxt = st_r;
    trial = '0;
    st_nxt.done = 1'b0;
    if (!st_r.busy) begin
      if (i_start) begin
        st_nxt.busy = 1'b1;
        st_nxt.num = i_num;
        st_nxt.den = (i_den == '0) ? W'(1) : i_den;
        st_nxt.rem = '0;
        st_nxt.cnt = 8'(W);
      end
    end else begin
      trial = {st_r.rem, st_r.num[W-1]} - {1'b0, st_r.den};
      st_nxt.num = {st_r.num[W-2:0], 1'b0};
      if (!trial[W]) begin
        st_nxt.rem = trial[W-1:0];
        st_nxt.quot = {st_r.quot[W-2:0], 1'b1};
      end else begin
        st_nxt.rem = {st_r.rem[W-2:0], st_r.num[W-1]};
        st_nxt.quot = {st_r.quot[W-2:0], 1'b0};
      end
      st_nxt.cnt = st_r.cnt - 8'h01;
      if (st_r.cnt == 8'h01) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_busy = st_r.busy;
  assign o_done = st_r.done;
  assign o_quot = st_r.quot;
endmodule : epedet_div

// ### epedet_monitor.sv
/*
 Checker for the margin, alarm and warning outputs of the detector.
 Assumes a bind into epedet_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module epedet_monitor #(
  parameter int POS_W = 32
) (
  // Clock, reset and inputs
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_CYCLE,
  input wire logic signed [POS_W-1:0] I_CMD_POS,
  input wire logic signed [POS_W-1:0] I_FB_POS,
  // Status outputs
  input wire logic [47:0] O_MARGIN,
  input wire logic [47:0] O_ALARM_PULSES,
  input wire logic [47:0] O_WARNING_PULSES,
  input wire logic O_THRESH_VALID,
  input wire logic O_EXCESSIVE_ERROR_ALARM,
  input wire logic O_EXCESSIVE_ERROR_WARNING
);
  logic signed [POS_W:0] diff;
  logic [47:0] mag;
  logic take;
  // Absolute error and the taken strobe
  assign diff = {I_CMD_POS[POS_W-1], I_CMD_POS} -
                {I_FB_POS[POS_W-1], I_FB_POS};
  assign mag = 48'(diff[POS_W] ? -diff : diff);
  assign take = I_CYCLE && O_THRESH_VALID;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  a_alarm_sticky: assert property (O_EXCESSIVE_ERROR_ALARM |=>
    O_EXCESSIVE_ERROR_ALARM) else $error("alarm dropped");
  a_alarm_raise: assert property (take && mag >= O_ALARM_PULSES |=>
    O_EXCESSIVE_ERROR_ALARM) else $error("alarm not raised");
  a_alarm_quiet: assert property (take && mag < O_ALARM_PULSES &&
    !O_EXCESSIVE_ERROR_ALARM |=> !O_EXCESSIVE_ERROR_ALARM)
    else $error("alarm below level");
  a_margin_value: assert property (take && mag < O_ALARM_PULSES |=>
    O_MARGIN == $past(O_ALARM_PULSES) - $past(mag))
    else $error("margin value wrong");
  a_margin_sat: assert property (take && mag >= O_ALARM_PULSES |=>
    O_MARGIN == 48'h0) else $error("margin not zero");
  a_margin_stands: assert property (!take |=> $stable(O_MARGIN))
    else $error("margin moved without cycle");
  a_margin_full: assert property (take && mag == 48'h0 |=>
    O_MARGIN == $past(O_ALARM_PULSES)) else $error("margin not full");
  a_warn_level: assert property (take |=> O_EXCESSIVE_ERROR_WARNING ==
    ($past(mag) >= $past(O_WARNING_PULSES))) else $error("warning wrong");
endmodule : epedet_monitor

bind epedet_top epedet_monitor #(.POS_W(POS_W)) epedet_monitor_i (
  .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_CYCLE(I_CYCLE),
  .I_CMD_POS(I_CMD_POS), .I_FB_POS(I_FB_POS), .O_MARGIN(O_MARGIN),
  .O_ALARM_PULSES(O_ALARM_PULSES), .O_WARNING_PULSES(O_WARNING_PULSES),
  .O_THRESH_VALID(O_THRESH_VALID),
  .O_EXCESSIVE_ERROR_ALARM(O_EXCESSIVE_ERROR_ALARM),
  .O_EXCESSIVE_ERROR_WARNING(O_EXCESSIVE_ERROR_WARNING));

// ### epedet_motion_model.sv
/*
 Command generator and encoder model: strobes a control cycle every
 fourth clock, moves the command and lags feedback by the given error.
 Assumes the bench sets the error and the enable.
*/
`timescale 1ns/1ps
module epedet_motion_model (
  // Clock and controls
  input wire logic clk,
  input wire logic en,
  input wire logic signed [31:0] err,
  // Toward the detector
  output logic cyc = 1'b0,
  output logic signed [31:0] cmd = 32'h00001000,
  output logic signed [31:0] fb = 32'h00001000
);
  logic [1:0] ph = 2'h0;
  logic en_s = 1'b0;
  logic signed [31:0] err_s = 32'h00000000;
  // Controls taken at the edge, so bench writes never race the model
  always @(posedge clk) begin
    en_s = en;
    err_s = err;
    #1;
    ph <= ph + 2'h1;
    cyc <= en_s && (ph == 2'h3);
    if (en_s && ph == 2'h3) begin
      cmd <= cmd + 32'h00000007;
      fb <= cmd + 32'h00000007 - err_s;
    end
  end
endmodule : epedet_motion_model

// ### epedet_top_tb.sv
/*
 Testbench of the detector: threshold table, margin and alarm, reset.
 Assumes the motion model drives the cycle strobe and positions.
*/
`timescale 1ns/1ps
module epedet_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b0;
  logic lin = 1'b0, fc = 1'b0, le = 1'b0;
  logic [1:0] mode = 2'h0, unit = 2'h0;
  logic [15:0] lvl = 16'h0000;
  logic signed [31:0] err = 32'h00000000;
  logic signed [31:0] cmd, fb;
  logic cyc, tv, alarm, warn;
  logic [47:0] margin, apul, wpul;
  int n_errors = 0, samples_checked = 0;
  // Clock of 5 ns
  always #2.5 clk = ~clk;
  epedet_motion_model epedet_motion_model_i (.clk(clk), .en(en),
    .err(err), .cyc(cyc), .cmd(cmd), .fb(fb));
  epedet_top epedet_top_i (.I_SYS_CLK(clk), .I_RST_N(rst_n),
    .I_CYCLE(cyc), .I_CMD_POS(cmd), .I_FB_POS(fb),
    .I_LINEAR_MOTOR(lin), .I_FULL_CLOSED(fc), .I_LINEAR_ENCODER(le),
    .I_CONTROL_MODE(mode), .I_TRIGGER_LEVEL_PARAM(lvl),
    .I_WARNING_LEVEL_PARAM(16'h0005), .I_UNIT_SELECT_PARAM(unit),
    .I_MOTOR_RES(24'h0003E8), .I_LOAD_RES(24'h0007D0),
    .I_LINEAR_RES_NUMERATOR(16'h0003),
    .I_LINEAR_RES_DENOMINATOR(16'h0002), .O_MARGIN(margin),
    .O_ALARM_PULSES(apul), .O_WARNING_PULSES(wpul), .O_THRESH_VALID(tv),
    .O_EXCESSIVE_ERROR_ALARM(alarm), .O_EXCESSIVE_ERROR_WARNING(warn));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic summarize;
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // Apply a setting, wait out both divider passes, compare thresholds
  task automatic thr(input logic [2:0] f, input logic [1:0] md,
    input logic [15:0] lv, input logic [1:0] un, input logic [47:0] ea,
    input logic [47:0] ew);
    {lin, fc, le} = f;
    mode = md;
    lvl = lv;
    unit = un;
    tick(110);
    for (int k = 0; k < 500 && (apul !== ea || wpul !== ew); k++)
      tick(1);
    check(tv, 1'b1);
    check(apul, ea);
    check(wpul, ew);
  endtask : thr
  task automatic scen_thresholds;
    thr(3'h0, 2'h0, 16'h00FA, 2'h0, 48'h030D40, 48'h1388);
    thr(3'h0, 2'h0, 16'h000F, 2'h1, 48'h0005DC, 48'h01F4);
    thr(3'h0, 2'h2, 16'h000F, 2'h1, 48'h003A98, 48'h1388);
    thr(3'h0, 2'h1, 16'h04D2, 2'h3, 48'h0004D2, 48'h0005);
    thr(3'h0, 2'h0, 16'h0007, 2'h2, 48'h000046, 48'h0032);
    thr(3'h2, 2'h0, 16'h0002, 2'h0, 48'h000FA0, 48'h2710);
    thr(3'h5, 2'h0, 16'h0000, 2'h0, 48'h0249F0, 48'h1D4C);
    thr(3'h5, 2'h3, 16'h012C, 2'h0, 48'h06DDD0, 48'h1D4C);
  endtask : scen_thresholds
  // Margin shrinks to zero, alarm rises and sticks, warning follows
  task automatic scen_margin;
    thr(3'h0, 2'h0, 16'h0000, 2'h1, 48'h000BB8, 48'h01F4);
    thr(3'h0, 2'h0, 16'h0000, 2'h0, 48'h000BB8, 48'h1388);
    en = 1'b1;
    err = 32'h00000BB7;
    tick(9);
    check(margin, 48'h1);
    check(alarm, 1'b0);
    err = 32'hFFFFF449;
    tick(8);
    check(margin, 48'h1);
    err = 32'h00000BB8;
    tick(8);
    check(margin, 48'h0);
    check(alarm, 1'b1);
    check(warn, 1'b0);
    err = 32'h00001388;
    tick(8);
    check(warn, 1'b1);
    err = 32'h00000000;
    tick(8);
    check(margin, 48'h000BB8);
    check(alarm, 1'b1);
    check(warn, 1'b0);
  endtask : scen_margin
  // A reset clears the alarm and the margin
  task automatic scen_reset;
    en = 1'b0;
    rst_n = 1'b0;
    tick(2);
    check(alarm, 1'b0);
    check(margin, 48'h0);
    check(tv, 1'b0);
    rst_n = 1'b1;
    thr(3'h0, 2'h0, 16'h0000, 2'h0, 48'h000BB8, 48'h1388);
  endtask : scen_reset
  // Main sequence
  initial begin
    tick(6);
    rst_n = 1'b1;
    scen_thresholds();
    scen_margin();
    scen_reset();
    summarize();
  end
  // Watchdog
  initial begin
    #100000;
    n_errors++;
    summarize();
  end
endmodule : epedet_top_tb
